/* design/rcs_defs.svh */
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RCS_OFF_POWER 8'h00
`define RCS_OFF_STATUS 8'h04
`define RCS_OFF_CTRL 8'h08
`define RCS_OFF_RESUME 8'h0C
`define RCS_OFF_IRQ_ST 8'h10
`define RCS_OFF_IRQ_MASK 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCS_PS_BROWNOUT 0
`define RCS_PS_POWERON 1
`define RCS_ST_EXPIRED 4
`define RCS_ST_SLEEP 3
`define RCS_CTRL_GIE 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCS_STATUS_RST 8'h18
`define RCS_POWER_RST 2'h0
`define RCS_SYNC_RST 7'h02
`define RCS_VEC_ZERO 13'h0000
`define RCS_VEC_IRQ 13'h0004

// ----------------------------------------
// Timing
// ----------------------------------------
`define RCS_CLK_MHZ 40
`define RCS_LONG_WAIT_US 72000
`define RCS_LONG_WAIT_CYC (`RCS_LONG_WAIT_US * `RCS_CLK_MHZ)
`define RCS_OSC_PERIODS 1024
`define RCS_BOOT_CYC 2'h3

`endif

/* design/rcs_pkg.sv */
package rcs_pkg;

	// Oscillator modes chosen by the two select fuses
	typedef enum logic [1:0] {
		OSC_LOW_POWER = 2'h0,
		OSC_STANDARD = 2'h1,
		OSC_HIGH_SPEED = 2'h2,
		OSC_RES_CAP = 2'h3
	} rcs_osc_t;

	// Reset and wake causes, numbered in priority order
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_POWER_ON = 3'h1,
		CAUSE_BROWNOUT = 3'h2,
		CAUSE_EXT_RUN = 3'h3,
		CAUSE_EXT_SLEEP = 3'h4,
		CAUSE_WDT_RESET = 3'h5,
		CAUSE_WDT_WAKE = 3'h6,
		CAUSE_IRQ_WAKE = 3'h7
	} rcs_cause_t;

	// Sequencer states, Gray along boot, long, osc, run
	typedef enum logic [1:0] {
		ST_BOOT = 2'h0,
		ST_LONG = 2'h1,
		ST_OSC = 2'h3,
		ST_RUN = 2'h2
	} rcs_state_t;

	// Which waits a cause needs
	typedef struct packed {
		logic long_wait;
		logic osc_wait;
	} rcs_plan_t;

	// One accepted bus address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} rcs_ahb_req_t;

endpackage

/* design/rcs_timeout.sv */
`timescale 1ns/10ps
`default_nettype none

// Down counter: done pulses exactly load cycles after start
module rcs_timeout (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [21:0] load,
	output logic busy,
	output logic done
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [21:0] cnt_q; // Remaining cycles minus one
	logic busy_q; // Counting
	logic done_q; // Terminal pulse
	logic [21:0] cnt_d;
	logic busy_d;
	logic done_d;

	// A fresh start always restarts the count
	assign cnt_d = start ? (load - 22'h000001) : (busy_q ? cnt_q - 22'h000001 : cnt_q);
	assign busy_d = start | (busy_q & (cnt_q != 22'h000000));
	assign done_d = ~start & busy_q & (cnt_q == 22'h000000);

	// Counter registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= 22'h000000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;

endmodule

`default_nettype wire

/* design/rcs_top.sv */
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defs.svh"

module rcs_top #(
	parameter int unsigned LONG_WAIT_CYC = `RCS_LONG_WAIT_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Fuses and reset pins, asynchronous
	input wire logic osc_select_hi,
	input wire logic osc_select_lo,
	input wire logic brownout_detect_enable,
	input wire logic powerup_timer_enable_n,
	input wire logic brownout_detect,
	input wire logic external_reset_pin_n,
	input wire logic watchdog_timer_expired,
	// Core side, same clock
	input wire logic cpu_sleep,
	input wire logic irq_wake_req,
	input wire logic [12:0] cpu_pc,
	output logic core_hold,
	output logic core_resume,
	output logic [12:0] resume_pc,
	output logic [7:0] cpu_status,
	output logic irq
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [6:0] sync1_q; // First stage, read only by sync2_q
	logic [6:0] sync2_q; // Stable copies
	logic [2:0] prev_q; // Previous event levels for edges
	logic [6:0] pins_w;

	assign pins_w = {powerup_timer_enable_n, brownout_detect_enable,
		osc_select_hi, osc_select_lo, watchdog_timer_expired,
		external_reset_pin_n, brownout_detect};

	// Two stages before any logic looks at a pin
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_q <= `RCS_SYNC_RST;
			sync2_q <= `RCS_SYNC_RST;
			prev_q <= 3'h2;
		end else begin
			sync1_q <= pins_w;
			sync2_q <= sync1_q;
			prev_q <= sync2_q[2:0];
		end
	end

	// Fuse fields
	logic powerup_timer_enable_n_n_w;
	logic brownout_detect_enable_w;
	rcs_pkg::rcs_osc_t osc_mode_w;

	assign powerup_timer_enable_n_n_w = sync2_q[6];
	assign brownout_detect_enable_w = sync2_q[5];
	assign osc_mode_w = rcs_pkg::rcs_osc_t'(sync2_q[4:3]);

	// Edge events
	logic bor_evt_w;
	logic ext_evt_w;
	logic wdt_evt_w;

	// Brown-out only counts while detection is fused on
	assign bor_evt_w = sync2_q[0] & ~prev_q[0] & brownout_detect_enable_w;
	assign ext_evt_w = ~sync2_q[1] & prev_q[1];
	assign wdt_evt_w = sync2_q[2] & ~prev_q[2];

	// ----------------------------------------
	// Sequencer state and cause
	// ----------------------------------------
	rcs_pkg::rcs_state_t state_q; // Sequencer state
	rcs_pkg::rcs_state_t state_d;
	logic [1:0] boot_cnt_q; // Lets fuse synchronisers fill
	rcs_pkg::rcs_plan_t plan_q; // Waits still owed
	logic boot_fire_w;
	logic asleep_w;
	rcs_pkg::rcs_cause_t cause_w;
	rcs_pkg::rcs_plan_t plan_w;

	// Power-on is raised once fuses are valid after release
	assign boot_fire_w = (state_q == rcs_pkg::ST_BOOT) && (boot_cnt_q == `RCS_BOOT_CYC);
	// Sleep is only meaningful while the core runs
	assign asleep_w = cpu_sleep & (state_q == rcs_pkg::ST_RUN);

	// Cause priority: power-on, brown-out, pin, watchdog, irq
	assign cause_w = boot_fire_w ? rcs_pkg::CAUSE_POWER_ON :
		bor_evt_w ? rcs_pkg::CAUSE_BROWNOUT :
		ext_evt_w ? (asleep_w ? rcs_pkg::CAUSE_EXT_SLEEP : rcs_pkg::CAUSE_EXT_RUN) :
		wdt_evt_w ? (asleep_w ? rcs_pkg::CAUSE_WDT_WAKE : rcs_pkg::CAUSE_WDT_RESET) :
		(asleep_w & irq_wake_req) ? rcs_pkg::CAUSE_IRQ_WAKE : rcs_pkg::CAUSE_NONE;

	// Waits needed for a cause in a mode
	function automatic rcs_pkg::rcs_plan_t timeout_plan(
		input rcs_pkg::rcs_osc_t mode,
		input rcs_pkg::rcs_cause_t cause,
		input logic ptmr_n
	);
		logic crystal;
		logic pwr;
		logic brown;
		logic wake;
		rcs_pkg::rcs_plan_t p;
		crystal = (mode != rcs_pkg::OSC_RES_CAP);
		pwr = (cause == rcs_pkg::CAUSE_POWER_ON);
		brown = (cause == rcs_pkg::CAUSE_BROWNOUT);
		wake = (cause == rcs_pkg::CAUSE_WDT_WAKE) || (cause == rcs_pkg::CAUSE_IRQ_WAKE);
		p.long_wait = (pwr & ~ptmr_n) | brown;
		p.osc_wait = crystal & (pwr | brown | wake);
		return p;
	endfunction

	// wait selection per mode and cause
	assign plan_w = timeout_plan(osc_mode_w, cause_w, powerup_timer_enable_n_n_w);

	// ----------------------------------------
	// Time-out counter
	// ----------------------------------------
	logic evt_w;
	logic tmr_start_w;
	logic [21:0] tmr_load_w;
	logic tmr_done_w;
	logic go_long_w;
	logic go_osc_w;
	logic finish_w;

	assign evt_w = (cause_w != rcs_pkg::CAUSE_NONE);
	assign go_long_w = evt_w & plan_w.long_wait;
	// Osc wait follows the long wait or starts on its own
	assign go_osc_w = (evt_w & ~plan_w.long_wait & plan_w.osc_wait) |
		(~evt_w & (state_q == rcs_pkg::ST_LONG) & tmr_done_w & plan_q.osc_wait);
	assign tmr_start_w = go_long_w | go_osc_w;
	// long wait is fixed time, osc wait is clock count
	assign tmr_load_w = go_long_w ? LONG_WAIT_CYC[21:0] : 22'(`RCS_OSC_PERIODS);
	// release only once the last wait is done
	assign finish_w = ~evt_w & tmr_done_w & ~go_osc_w &
		((state_q == rcs_pkg::ST_LONG) || (state_q == rcs_pkg::ST_OSC));

	rcs_timeout u_timeout (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(tmr_start_w),
		.load(tmr_load_w),
		.busy(),
		.done(tmr_done_w)
	);

	// Next state; a new cause always restarts the sequence
	assign state_d = go_long_w ? rcs_pkg::ST_LONG :
		go_osc_w ? rcs_pkg::ST_OSC :
		(evt_w | finish_w) ? rcs_pkg::ST_RUN : state_q;

	// Sequencer registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= rcs_pkg::ST_BOOT;
			boot_cnt_q <= 2'h0;
			plan_q <= '0;
		end else begin
			state_q <= state_d;
			boot_cnt_q <= boot_cnt_q + ((state_q == rcs_pkg::ST_BOOT) ? 2'h1 : 2'h0);
			if (evt_w) begin
				plan_q <= plan_w;
			end
		end
	end

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	rcs_pkg::rcs_ahb_req_t ap_w; // Address phase this cycle
	rcs_pkg::rcs_ahb_req_t dp_q; // Pending data phase
	logic hreadyout_q;
	logic hresp_q;
	logic [31:0] hrdata_q;
	logic [31:0] rdata_w; // Read mux result, built further down

	assign ap_w.valid = hsel & htrans[1] & hready;
	assign ap_w.write = hwrite;
	assign ap_w.addr = haddr[7:0];

	// One-hot register select; unmapped gives zero
	function automatic logic [5:0] reg_sel(input logic [7:0] a);
		case (a)
			`RCS_OFF_POWER: reg_sel = 6'h01;
			`RCS_OFF_STATUS: reg_sel = 6'h02;
			`RCS_OFF_CTRL: reg_sel = 6'h04;
			`RCS_OFF_RESUME: reg_sel = 6'h08;
			`RCS_OFF_IRQ_ST: reg_sel = 6'h10;
			`RCS_OFF_IRQ_MASK: reg_sel = 6'h20;
			default: reg_sel = 6'h00;
		endcase
	endfunction

	logic [5:0] wsel_w;
	logic [5:0] rsel_w;
	logic wr_w;

	assign wr_w = dp_q.valid & dp_q.write;
	assign wsel_w = wr_w ? reg_sel(dp_q.addr) : 6'h00;
	assign rsel_w = reg_sel(dp_q.addr);

	// Reads take one wait state so a write just before is seen
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dp_q <= '0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h00000000;
		end else begin
			dp_q <= ap_w;
			hreadyout_q <= ~(ap_w.valid & ~ap_w.write);
			if (dp_q.valid & ~dp_q.write) begin
				hrdata_q <= rdata_w;
			end
		end
	end

	// ----------------------------------------
	// Software visible registers
	// ----------------------------------------
	logic [1:0] power_q; // Power status flags
	logic [1:0] power_d;
	logic [7:0] status_q; // Core status byte
	logic [7:0] status_d;
	logic gie_q; // Global interrupt enable copy
	logic [12:0] rpc_q; // Resume address
	logic [12:0] rpc_d;
	logic resume_q; // Release pulse
	logic resume_d;
	logic hold_q; // Core held
	logic hold_d;
	logic [5:0] irq_st_q; // Sticky events
	logic [5:0] irq_st_d;
	logic [5:0] irq_mask_q; // Event mask
	logic irq_q;

	// Status byte after a cause; u bits keep old value
	function automatic logic [7:0] status_after(
		input rcs_pkg::rcs_cause_t c,
		input logic [7:0] s
	);
		logic [7:0] r;
		r = s;
		case (c)
			// power-on sets expired and sleep flags
			rcs_pkg::CAUSE_POWER_ON: r = `RCS_STATUS_RST;
			// brown-out, watchdog reset and watchdog wake
			rcs_pkg::CAUSE_BROWNOUT: r = {3'h0, 2'h3, s[2:0]};
			rcs_pkg::CAUSE_WDT_RESET: r = {3'h0, 2'h1, s[2:0]};
			rcs_pkg::CAUSE_WDT_WAKE: r = {s[7:5], 2'h0, s[2:0]};
			// pin reset in sleep and irq wake
			rcs_pkg::CAUSE_EXT_SLEEP: r = {3'h0, 2'h2, s[2:0]};
			rcs_pkg::CAUSE_IRQ_WAKE: r = {s[7:5], 2'h2, s[2:0]};
			// pin reset while running clears upper bits
			rcs_pkg::CAUSE_EXT_RUN: r = {3'h0, s[4:0]};
			default: r = s;
		endcase
		return r;
	endfunction

	// Hardware cause wins over a software write in the same cycle
	assign status_d = evt_w ? status_after(cause_w, status_q) :
		wsel_w[1] ? {hwdata[7:5], status_q[4:3], hwdata[2:0]} : status_q;

	// power-on loads brown-out flag from detect enable
	// power-on clears its own flag, software sets it
	// brown-out clears its flag, software sets it
	assign power_d = (cause_w == rcs_pkg::CAUSE_POWER_ON) ? {1'b0, brownout_detect_enable_w} :
		(cause_w == rcs_pkg::CAUSE_BROWNOUT) ? {power_q[1], 1'b0} :
		wsel_w[0] ? hwdata[1:0] : power_q;

	// resets restart at zero, wakes at next address
	// irq wake with interrupts on goes to the vector
	assign rpc_d = (cause_w == rcs_pkg::CAUSE_IRQ_WAKE) ?
		(gie_q ? `RCS_VEC_IRQ : cpu_pc + 13'h0001) :
		(cause_w == rcs_pkg::CAUSE_WDT_WAKE) ? cpu_pc + 13'h0001 :
		evt_w ? `RCS_VEC_ZERO : rpc_q;

	// hold rises for every cause, even one with no wait
	assign hold_d = (state_d != rcs_pkg::ST_RUN) | (evt_w & ~tmr_start_w);
	// Release pulse marks the edge at which hold drops, so the two never disagree
	assign resume_d = hold_q & ~hold_d;

	// Event sources for sticky bits
	logic [5:0] irq_set_w;

	assign irq_set_w = {
		resume_d,
		(cause_w == rcs_pkg::CAUSE_WDT_WAKE) || (cause_w == rcs_pkg::CAUSE_IRQ_WAKE),
		cause_w == rcs_pkg::CAUSE_WDT_RESET,
		(cause_w == rcs_pkg::CAUSE_EXT_RUN) || (cause_w == rcs_pkg::CAUSE_EXT_SLEEP),
		cause_w == rcs_pkg::CAUSE_BROWNOUT,
		cause_w == rcs_pkg::CAUSE_POWER_ON
	};

	// Write one to clear; a set in the same cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sticky
			assign irq_st_d[gi] = irq_set_w[gi] |
				(irq_st_q[gi] & ~(wsel_w[4] & hwdata[gi]));
		end
	endgenerate

	// Register file
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_q <= `RCS_POWER_RST;
			status_q <= `RCS_STATUS_RST;
			gie_q <= 1'b0;
			irq_st_q <= 6'h00;
			irq_mask_q <= 6'h00;
		end else begin
			power_q <= power_d;
			status_q <= status_d;
			irq_st_q <= irq_st_d;
			if (wsel_w[2]) begin
				gie_q <= hwdata[`RCS_CTRL_GIE];
			end
			if (wsel_w[5]) begin
				irq_mask_q <= hwdata[5:0];
			end
		end
	end

	// core held from reset until the wait ends
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rpc_q <= `RCS_VEC_ZERO;
			hold_q <= 1'b1;
			resume_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rpc_q <= rpc_d;
			hold_q <= hold_d;
			resume_q <= resume_d;
			irq_q <= |(irq_st_d & irq_mask_q);
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// flags sit in the two low bits
	assign rdata_w = rsel_w[0] ? {30'h0, power_q} :
		rsel_w[1] ? {24'h0, status_q} :
		rsel_w[2] ? {24'h0, powerup_timer_enable_n_n_w, brownout_detect_enable_w, sync2_q[4:3], 3'h0, gie_q} :
		rsel_w[3] ? {14'h0, state_q, 3'h0, rpc_q} :
		rsel_w[4] ? {26'h0, irq_st_q} :
		rsel_w[5] ? {26'h0, irq_mask_q} : 32'h00000000;

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign core_hold = hold_q;
	assign core_resume = resume_q;
	assign resume_pc = rpc_q;
	assign cpu_status = status_q;
	assign irq = irq_q;

endmodule

`default_nettype wire

/* verification/rcs_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Port-level watcher of the sequencer
// ----------------------------------------
module rcs_top_chk #(
	parameter int unsigned LONG_WAIT_CYC = 20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic external_reset_pin_n,
	input wire logic cpu_sleep,
	input wire logic core_hold,
	input wire logic core_resume,
	input wire logic [7:0] cpu_status,
	input wire logic irq
);
	// Accepted address phases
	logic take_q;
	logic rd_take;
	assign take_q = hsel & htrans[1] & hready;
	assign rd_take = take_q & !hwrite;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_hresp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take_q && hwrite |=> hreadyout)
		else $error("write stalled");
	// Read data only moves when a read finishes
	a_rdata_holds: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved");
	a_por_state: assert property ($fell(sys_rst) |-> cpu_status == 8'h18 && core_hold && !irq)
		else $error("power-on state wrong");
	a_resume_pulse: assert property (core_resume |=> !core_resume)
		else $error("resume longer than one cycle");
	a_hold_release: assert property ($fell(core_hold) |-> core_resume)
		else $error("hold dropped without resume");
	a_pin_hold: assert property ($fell(external_reset_pin_n) && !core_hold |-> ##[2:8] core_hold)
		else $error("pin reset not held");
	a_ext_run_status: assert property ($fell(external_reset_pin_n) && !cpu_sleep && !core_hold
		|-> ##[3:8] cpu_status[7:5] == 3'h0)
		else $error("upper status bits kept");

	c_read: cover property (rd_take);
	c_release: cover property ($fell(core_hold));
	c_irq: cover property (irq);
endmodule

bind rcs_top rcs_top_chk #(.LONG_WAIT_CYC(LONG_WAIT_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .external_reset_pin_n(external_reset_pin_n),
	.cpu_sleep(cpu_sleep), .core_hold(core_hold), .core_resume(core_resume),
	.cpu_status(cpu_status), .irq(irq));

`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defs.svh"

// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb_top;
	// Short long-wait keeps the run small
	localparam int unsigned LW = 20;
	typedef struct packed {logic [1:0] osc; logic en_n; logic bden; logic [31:0] wt;} rcs_row_t;
	logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, bo = 1'b0, wdt = 1'b0;
	logic [1:0] htrans = 2'h0, osc = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic en_n = 1'b0, bden = 1'b0, pin_n = 1'b1, slp = 1'b0, wreq = 1'b0;
	logic [12:0] cpu_pc = 13'h0000, resume_pc;
	logic hreadyout, hresp, core_hold, core_resume, irq;
	logic [7:0] cpu_status;
	int n_mismatch = 0, check_count = 0, base = 0, cnt = 0;
	// Fuses and the extra wait each should give
	rcs_row_t rows [8] = '{'{2'h3, 1'b1, 1'b0, 0}, '{2'h0, 1'b0, 1'b1, LW + 1024},
		'{2'h1, 1'b1, 1'b0, 1024}, '{2'h2, 1'b1, 1'b1, 1024}, '{2'h3, 1'b0, 1'b1, LW},
		'{2'h0, 1'b1, 1'b0, 1024}, '{2'h1, 1'b0, 1'b0, LW + 1024}, '{2'h2, 1'b0, 1'b1, LW + 1024}};

	always #12.5 clk = ~clk;

	rcs_top #(.LONG_WAIT_CYC(LW)) i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.osc_select_hi(osc[1]), .osc_select_lo(osc[0]), .brownout_detect_enable(bden),
		.powerup_timer_enable_n(en_n), .brownout_detect(bo), .external_reset_pin_n(pin_n),
		.watchdog_timer_expired(wdt), .cpu_sleep(slp), .irq_wake_req(wreq), .cpu_pc(cpu_pc),
		.core_hold(core_hold), .core_resume(core_resume), .resume_pc(resume_pc),
		.cpu_status(cpu_status), .irq(irq));

	task summarize();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait: 0 bus ready, 1 hold, 2 resume
	task wfor(input int s, input int lim);
		logic hit;
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
			hit = (s == 0) ? hreadyout === 1'b1 : (s == 1) ? core_hold === 1'b1 : core_resume === 1'b1;
		end while (!hit && cnt < lim);
		if (!hit) begin
			n_mismatch++;
			$display("mismatch at %0t: wait %h gave up after %h", $time, s, lim);
			summarize();
		end
	endtask

	// One single-word transfer, held until ready
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		wfor(0, 20);
		htrans <= 2'h0;
		hwdata <= wd;
		wfor(0, 20);
		rd = hrdata;
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Event: 0 pin, 1 watchdog, 2 brown-out, 3 wake interrupt
	task fire(input int k, input logic s, input logic [7:0] st, input logic [12:0] pc);
		slp <= s;
		repeat (2) @(posedge clk);
		pin_n <= (k != 0);
		wdt <= (k == 1);
		bo <= (k == 2);
		wreq <= (k == 3);
		wfor(1, 20);
		{pin_n, wdt, bo, wreq, slp} <= 5'h10;
		wfor(2, 5000);
		repeat (2) @(posedge clk);
		chk({24'h0, cpu_status}, {24'h0, st});
		chk({19'h0, resume_pc}, {19'h0, pc});
	endtask

	initial begin
		// Power-on under every pairing of oscillator mode and timer fuse (eight of the sixteen fuse settings)
		for (int r = 0; r < 8; r++) begin
			{osc, en_n, bden} <= {rows[r].osc, rows[r].en_n, rows[r].bden};
			sys_rst <= 1'b1;
			repeat (12) @(posedge clk);
			sys_rst <= 1'b0;
			wfor(2, 5000);
			if (r == 0) base = cnt;
			chk({31'h0, cnt - base >= rows[r].wt && cnt - base <= rows[r].wt + 2}, 32'h1);
			chk({19'h0, resume_pc}, 32'h0);
			chk({24'h0, cpu_status}, 32'h18);
			rdchk(`RCS_OFF_POWER, {31'h0, rows[r].bden});
			rdchk(`RCS_OFF_CTRL, {24'h0, rows[r].en_n, rows[r].bden, rows[r].osc, 4'h0});
		end
		// Software sets flags; status sense bits stay read-only
		bus(1'b1, `RCS_OFF_POWER, 32'h3);
		bus(1'b1, `RCS_OFF_STATUS, 32'hE0);
		rdchk(`RCS_OFF_STATUS, 32'hF8);
		bus(1'b1, `RCS_OFF_IRQ_MASK, 32'h0);
		bus(1'b1, `RCS_OFF_IRQ_ST, 32'h3F);
		fire(0, 1'b0, 8'h18, 13'h0000);
		rdchk(`RCS_OFF_POWER, 32'h3);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, `RCS_OFF_IRQ_MASK, 32'h4);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, `RCS_OFF_IRQ_ST, 32'h4);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		fire(1, 1'b0, 8'h08, 13'h0000);
		fire(2, 1'b0, 8'h18, 13'h0000);
		rdchk(`RCS_OFF_POWER, 32'h2);
		bus(1'b1, `RCS_OFF_POWER, 32'h3);
		cpu_pc <= 13'h0123;
		fire(1, 1'b1, 8'h00, 13'h0124);
		fire(3, 1'b1, 8'h10, 13'h0124);
		bus(1'b1, `RCS_OFF_CTRL, 32'h1);
		fire(3, 1'b1, 8'h10, 13'h0004);
		rdchk(`RCS_OFF_RESUME, 32'h00020004);
		fire(0, 1'b1, 8'h10, 13'h0000);
		rdchk(`RCS_OFF_POWER, 32'h3);
		// Unmapped place reads zero and ignores writes
		bus(1'b1, 8'h20, 32'hFFFFFFFF);
		rdchk(8'h20, 32'h0);
		summarize();
	end
endmodule

`default_nettype wire
